// ---- src/rps_sequencer.sv ----
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rps_consts.svh"
module rps_sequencer
	import rps_pkg::*;
#(
	parameter int RATIO = 8,
	parameter int BCLK_DIV = 2
) (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic BUS_CLK_EN,
	input wire logic CORE_POWER_OK,
	input wire logic TERMINATION_POWER_OK,
	input wire logic COLD_RESET_N,
	input wire rps_pkg::rps_straps_s STRAPS_IN,
	output logic [1:0] BUS_SPEED_SELECT,
	output logic [3:0] VOLTAGE_ID_CODE,
	output logic SPEC_READY,
	output logic OUTPUTS_VALID,
	output logic BUS_DRIVE_EN,
	output logic SLOW_PULSE_OUT
);
	import rps_pkg::*;

	// elaboration checks on the parameters
	if (RATIO < 6 || RATIO > 8) begin : bad_ratio_g
		$error("RATIO must be 6, 7 or 8");
	end
	if (BCLK_DIV < 1) begin : bad_div_g
		$error("BCLK_DIV must be at least 1");
	end

	// fixed ratio code, no write path alters it
	localparam logic [3:0] RATIO_CODE = (RATIO == 6) ? `RPS_ENC_X6 :
		(RATIO == 7) ? `RPS_ENC_X7 : `RPS_ENC_X8;
	localparam logic [31:0] CFG_WORD =
		{4'h0, 1'b0, 1'b0, RATIO_CODE, 22'h0};

	logic [2:0] pok_sync_reg;
	logic [2:0] tok_sync_reg;
	logic [2:0] rst_sync_reg;
	logic pok_reg;
	logic tok_reg;
	logic rstn_reg;
	rps_straps_s strap_s1_reg;
	rps_straps_s strap_s2_reg;
	rps_straps_s strap_cap_reg;
	rps_state_e state_reg;
	logic [2:0] rel_cnt_reg;
	logic [15:0] vid_cnt_reg;
	logic [1:0] bus_speed_select_reg;
	logic [3:0] vid_reg;
	logic pulse_req_reg;
	logic [1:0] pulse_cnt_reg;
	logic slow_out_reg;
	logic bclk;
	logic wr_en;
	logic rd_en;

	assign bclk = BUS_CLK_EN;

	// three flop synchronisers; change taken when 2nd and 3rd agree
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pok_sync_reg <= 3'h0;
			tok_sync_reg <= 3'h0;
			rst_sync_reg <= 3'h0;
			pok_reg <= 1'b0;
			tok_reg <= 1'b0;
			rstn_reg <= 1'b0;
		end else begin
			pok_sync_reg <= {pok_sync_reg[1:0], CORE_POWER_OK};
			tok_sync_reg <= {tok_sync_reg[1:0], TERMINATION_POWER_OK};
			rst_sync_reg <= {rst_sync_reg[1:0], COLD_RESET_N};
			if (pok_sync_reg[1] == pok_sync_reg[2])
				pok_reg <= pok_sync_reg[2];
			if (tok_sync_reg[1] == tok_sync_reg[2])
				tok_reg <= tok_sync_reg[2];
			if (rst_sync_reg[1] == rst_sync_reg[2])
				rstn_reg <= rst_sync_reg[2];
		end
	end

	// strap pipeline aligned with the reset synchroniser
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			strap_s1_reg <= '0;
			strap_s2_reg <= '0;
		end else begin
			strap_s1_reg <= STRAPS_IN;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// sequencing state machine
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state_reg <= ST_OFF;
			rel_cnt_reg <= 3'h0;
		end else begin
			case (state_reg)
				ST_OFF: begin
					if (tok_reg)
						state_reg <= ST_TERM;
				end
				ST_TERM: begin
					if (!tok_reg)
						state_reg <= ST_OFF;
					else if (pok_reg)
						state_reg <= ST_RESET;
				end
				ST_RESET: begin
					rel_cnt_reg <= 3'h0;
					if (!pok_reg || !tok_reg)
						state_reg <= ST_OFF;
					else if (rstn_reg)
						state_reg <= ST_QUIET;
				end
				ST_QUIET: begin
					if (!rstn_reg || !pok_reg)
						state_reg <= ST_RESET;
					else if (bclk) begin
						rel_cnt_reg <= rel_cnt_reg + 3'h1;
						if (rel_cnt_reg == 3'(`RPS_DRIVE_BCLK - 1))
							state_reg <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!rstn_reg || !pok_reg)
						state_reg <= ST_RESET;
				end
				default: state_reg <= ST_OFF;
			endcase
		end
	end

	// capture straps on the edge that sees reset go inactive
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			strap_cap_reg <= '0;
		else if (state_reg == ST_RESET && rstn_reg)
			strap_cap_reg <= strap_s2_reg;
	end

	// speed select and voltage code settle before termination power
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			vid_cnt_reg <= 16'h0;
		else if (vid_cnt_reg != 16'(`RPS_BUS_SPEED_SELECT_VALID_CYC))
			vid_cnt_reg <= vid_cnt_reg + 16'h1;
	end
	assign SPEC_READY = (vid_cnt_reg == 16'(`RPS_BUS_SPEED_SELECT_VALID_CYC));

	// apb slave, zero wait states
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PWRITE;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;

	// ctrl register and slow pulse request
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			bus_speed_select_reg <= 2'h0;
			vid_reg <= 4'h0;
			pulse_req_reg <= 1'b0;
		end else begin
			if (wr_en && PADDR == `RPS_OFF_CTRL) begin
				bus_speed_select_reg <= PWDATA[`RPS_CTRL_BUS_SPEED_SELECT_LSB +: 2];
				vid_reg <= PWDATA[`RPS_CTRL_VID_LSB +: 4];
			end
			if (wr_en && PADDR == `RPS_OFF_PULSE && PWDATA[0])
				pulse_req_reg <= 1'b1;
			else if (pulse_cnt_reg == 2'h0 && bclk) // cleared as it fires
				pulse_req_reg <= 1'b0;
		end
	end

	// slow output pulse stretched to two bus clocks
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			pulse_cnt_reg <= 2'h0;
			slow_out_reg <= 1'b0;
		end else if (pulse_cnt_reg == 2'h0) begin
			if (pulse_req_reg && bclk) begin
				slow_out_reg <= 1'b1;
				pulse_cnt_reg <= 2'(`RPS_PULSE_BCLK);
			end
		end else if (bclk) begin
			pulse_cnt_reg <= pulse_cnt_reg - 2'h1;
			if (pulse_cnt_reg == 2'h1)
				slow_out_reg <= 1'b0;
		end
	end

	// read mux
	always_ff @(posedge CLK_SYS) begin
		if (RESET)
			PRDATA <= 32'h0;
		else if (rd_en) begin
			case (PADDR)
				`RPS_OFF_CTRL: PRDATA <= {24'h0, vid_reg, 2'h0, bus_speed_select_reg};
				`RPS_OFF_STATUS: PRDATA <= {24'h0, SPEC_READY,
					3'h0, 3'h0, state_reg == ST_RUN};
				`RPS_OFF_STRAPS: PRDATA <= {17'h0, strap_cap_reg};
				`RPS_OFF_CFG: PRDATA <= CFG_WORD;
				default: PRDATA <= 32'h0;
			endcase
		end
	end

	// outputs valid after 1 bus clock, drive after 4
	assign OUTPUTS_VALID = (state_reg == ST_RUN) ||
		(state_reg == ST_QUIET &&
		rel_cnt_reg >= 3'(`RPS_VALID_BCLK));
	assign BUS_DRIVE_EN = (state_reg == ST_RUN);
	assign BUS_SPEED_SELECT = bus_speed_select_reg;
	assign VOLTAGE_ID_CODE = vid_reg;
	assign SLOW_PULSE_OUT = slow_out_reg;

	// release timing, pulse width, strap capture, ratio word and speed select ready timing
	drive_late_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) $rose(BUS_DRIVE_EN) |->
		$past(state_reg) == ST_QUIET && $past(rel_cnt_reg) == 3'h3)
		else $error("bus drive started early");
	valid_late_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) $rose(OUTPUTS_VALID) |-> rel_cnt_reg != 3'h0)
		else $error("outputs valid too early");
	pulse_width_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) $rose(SLOW_PULSE_OUT) |-> pulse_cnt_reg == 2'h2)
		else $error("slow pulse too short");
	pulse_hold_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) $fell(SLOW_PULSE_OUT) |->
		$past(pulse_cnt_reg) == 2'h1)
		else $error("slow pulse ended early");
	ratio_code_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) CFG_WORD[`RPS_CFG_B27] == 1'b0 &&
		CFG_WORD[`RPS_CFG_RATIO_LSB +: 4] == RATIO_CODE)
		else $error("ratio code wrong");
	strap_hold_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET)
		state_reg == ST_RUN && $past(state_reg) == ST_RUN |->
		$stable(strap_cap_reg))
		else $error("captured straps changed");
	strap_take_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET)
		state_reg == ST_QUIET && $past(state_reg) == ST_RESET |->
		strap_cap_reg == $past(strap_s2_reg))
		else $error("straps not captured");
	spec_ready_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) $rose(SPEC_READY) |->
		$past(vid_cnt_reg) == 16'(`RPS_BUS_SPEED_SELECT_VALID_CYC - 1))
		else $error("speed select ready timing wrong");

	// release order, counting from zero and power loss
	reset_quiet_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) !rstn_reg |=> !BUS_DRIVE_EN && !OUTPUTS_VALID)
		else $error("outputs active during cold reset");
	power_loss_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) !pok_reg |=> !BUS_DRIVE_EN)
		else $error("bus still driven after power loss");
	valid_first_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) BUS_DRIVE_EN |-> OUTPUTS_VALID)
		else $error("bus driven before outputs valid");
	quiet_count_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) state_reg == ST_QUIET |-> rel_cnt_reg <= 3'h3)
		else $error("release count overran");
	quiet_start_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) $rose(state_reg == ST_QUIET) |->
		rel_cnt_reg == 3'h0)
		else $error("release count not cleared");

	// slow pulse start and first bus clock
	pulse_start_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) pulse_req_reg && pulse_cnt_reg == 2'h0 && bclk
		|=> SLOW_PULSE_OUT)
		else $error("slow pulse did not start");
	pulse_mid_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) SLOW_PULSE_OUT && pulse_cnt_reg == 2'h2 && bclk
		|=> SLOW_PULSE_OUT)
		else $error("slow pulse cut after one bus clock");

	// captured straps, ready flag and ratio read back
	strap_only_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) !$stable(strap_cap_reg) |->
		$past(state_reg) == ST_RESET && $past(rstn_reg))
		else $error("straps changed outside capture");
	spec_hold_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) SPEC_READY |=> SPEC_READY)
		else $error("speed select ready dropped");
	cfg_read_a: assert property (@(posedge CLK_SYS)
		disable iff (RESET) rd_en && PADDR == `RPS_OFF_CFG |=>
		PRDATA[`RPS_CFG_B27] == 1'b0 &&
		PRDATA[`RPS_CFG_RATIO_LSB +: 4] == 4'(RATIO + 5))
		else $error("ratio word read wrong");
endmodule
`default_nettype wire

// ---- include/rps_consts.svh ----
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH
// apb register byte offsets
`define RPS_OFF_CTRL 12'h000
`define RPS_OFF_STATUS 12'h004
`define RPS_OFF_STRAPS 12'h008
`define RPS_OFF_CFG 12'h00c
`define RPS_OFF_PULSE 12'h010
// ctrl fields
`define RPS_CTRL_BUS_SPEED_SELECT_LSB 0
`define RPS_CTRL_VID_LSB 4
`define RPS_CTRL_RST 32'h0000_0000
// config field positions (bit 27 and 25:22)
`define RPS_CFG_B27 27
`define RPS_CFG_RATIO_LSB 22
// ratio encodings
`define RPS_ENC_X6 4'hb
`define RPS_ENC_X7 4'hc
`define RPS_ENC_X8 4'hd
// timing
`define RPS_CLK_MHZ 250
`define RPS_VALID_BCLK 1
`define RPS_DRIVE_BCLK 4
`define RPS_PULSE_BCLK 2
`define RPS_BUS_SPEED_SELECT_VALID_US 1
`define RPS_BUS_SPEED_SELECT_VALID_CYC (`RPS_BUS_SPEED_SELECT_VALID_US * `RPS_CLK_MHZ)
`endif

// ---- include/rps_pkg.sv ----
package rps_pkg;
	typedef struct packed {
		logic [10:0] addr;
		logic bus_request_strap;
		logic flush;
		logic warm_init;
		logic interrupt_bus_data0;
	} rps_straps_s;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rps_apb_req_s;
	typedef enum logic [4:0] {
		ST_OFF = 5'b00001,
		ST_TERM = 5'b00010,
		ST_RESET = 5'b00100,
		ST_QUIET = 5'b01000,
		ST_RUN = 5'b10000
	} rps_state_e;
endpackage

// ---- tb/rps_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rps_board_model #(
	parameter int SETTLE = 40
) (
	input wire logic CLK_SYS,
	input wire logic GO,
	input wire logic SPEC_READY,
	input wire rps_pkg::rps_straps_s STRAP_VAL,
	output logic BUS_CLK_EN,
	output logic CORE_POWER_OK,
	output logic TERMINATION_POWER_OK,
	output logic COLD_RESET_N,
	output rps_pkg::rps_straps_s STRAPS_IN
);
	import rps_pkg::*;
	// waits whole bus clocks
	task automatic bclk(input int n);
		repeat (n) begin
			@(posedge CLK_SYS);
			while (!BUS_CLK_EN) @(posedge CLK_SYS);
		end
	endtask
	// bus clock enable, one pulse every two cycles
	initial BUS_CLK_EN = 1'b0;
	always @(posedge CLK_SYS) BUS_CLK_EN <= !BUS_CLK_EN;
	// board power-up and reset order
	initial begin
		CORE_POWER_OK = 1'b0;
		TERMINATION_POWER_OK = 1'b0;
		COLD_RESET_N = 1'b0;
		STRAPS_IN = '0;
		wait (GO);
		@(posedge CLK_SYS);
		while (!SPEC_READY) @(posedge CLK_SYS);
		bclk(SETTLE);
		TERMINATION_POWER_OK <= 1'b1;
		bclk(SETTLE);
		CORE_POWER_OK <= 1'b1;
		STRAPS_IN <= STRAP_VAL;
		bclk(SETTLE);
		COLD_RESET_N <= 1'b1;
		bclk(3);
		STRAPS_IN <= ~STRAP_VAL;
	end
endmodule
`default_nettype wire

// ---- tb/rps_sequencer_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rps_consts.svh"
module rps_sequencer_test;
	import rps_pkg::*;
	logic CLK_SYS, RESET, PSEL, PENABLE, PWRITE, GO, PREADY, PSLVERR;
	logic BUS_CLK_EN, CORE_POWER_OK, TERMINATION_POWER_OK, COLD_RESET_N;
	logic SPEC_READY, OUTPUTS_VALID, BUS_DRIVE_EN, SLOW_PULSE_OUT;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, r;
	logic [1:0] BUS_SPEED_SELECT;
	logic [3:0] VOLTAGE_ID_CODE;
	rps_straps_s STRAPS_IN, sv;
	int fail_count = 0, total_checks = 0, n, cyc;
	logic [31:0] exp_q[$];
	rps_sequencer #(.RATIO(7)) dut (.CLK_SYS(CLK_SYS), .RESET(RESET),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .BUS_CLK_EN(BUS_CLK_EN),
		.CORE_POWER_OK(CORE_POWER_OK), .COLD_RESET_N(COLD_RESET_N),
		.TERMINATION_POWER_OK(TERMINATION_POWER_OK), .STRAPS_IN(STRAPS_IN),
		.BUS_SPEED_SELECT(BUS_SPEED_SELECT), .SPEC_READY(SPEC_READY),
		.VOLTAGE_ID_CODE(VOLTAGE_ID_CODE), .OUTPUTS_VALID(OUTPUTS_VALID),
		.BUS_DRIVE_EN(BUS_DRIVE_EN), .SLOW_PULSE_OUT(SLOW_PULSE_OUT));
	rps_board_model board (.CLK_SYS(CLK_SYS), .GO(GO),
		.SPEC_READY(SPEC_READY), .STRAP_VAL(sv), .BUS_CLK_EN(BUS_CLK_EN),
		.CORE_POWER_OK(CORE_POWER_OK), .COLD_RESET_N(COLD_RESET_N),
		.TERMINATION_POWER_OK(TERMINATION_POWER_OK), .STRAPS_IN(STRAPS_IN));
	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS); // idle edge between transfers
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// read monitor takes the oldest note
	always @(posedge CLK_SYS)
		if (PSEL && PENABLE && PREADY && !PWRITE) begin
			check(PRDATA, exp_q.pop_front());
			check(32'(PSLVERR), 32'h0);
		end
	// cycles since reset release
	always @(posedge CLK_SYS) cyc <= RESET ? 0 : cyc + 1;
	initial begin
		CLK_SYS = 1'b0;
		forever #2 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		fail_count++;
		wrap_up();
	end
	initial begin
		{RESET, PSEL, PENABLE, PWRITE, GO, PADDR, PWDATA} = '0;
		RESET = 1'b1;
		sv = '0;
		void'($urandom(40652));
		repeat (5) @(posedge CLK_SYS);
		RESET <= 1'b0;
		@(posedge CLK_SYS);
		rd(`RPS_OFF_CFG, 32'(`RPS_ENC_X7) << `RPS_CFG_RATIO_LSB);
		apb(1'b1, 12'h0f0, 32'hffff_ffff);
		rd(12'h0f0, 32'h0);
		r = $urandom & 32'hf3;
		apb(1'b1, `RPS_OFF_CTRL, r);
		rd(`RPS_OFF_CTRL, r);
		check(32'(BUS_SPEED_SELECT), 32'(r[1:0]));
		check(32'(VOLTAGE_ID_CODE), 32'(r[7:4]));
		check(32'(SPEC_READY), 32'h0);
		sv = rps_straps_s'(15'($urandom));
		GO <= 1'b1;
		wait (SPEC_READY);
		@(negedge CLK_SYS);
		check(32'(cyc), 32'(`RPS_BUS_SPEED_SELECT_VALID_CYC));
		wait (COLD_RESET_N);
		n = 0;
		while (BUS_DRIVE_EN !== 1'b1 && n < 30) begin
			@(posedge CLK_SYS);
			check(32'(OUTPUTS_VALID !== 1'b0 && n < 1), 32'h0);
			n += int'(BUS_CLK_EN);
		end
		check(32'(n >= 4 && n < 30), 32'h1);
		check(32'(OUTPUTS_VALID), 32'h1);
		rd(`RPS_OFF_STRAPS, 32'(sv));
		rd(`RPS_OFF_STATUS, 32'h81);
		apb(1'b1, `RPS_OFF_PULSE, 32'h1);
		wait (SLOW_PULSE_OUT);
		n = 0;
		while (SLOW_PULSE_OUT === 1'b1) begin
			@(posedge CLK_SYS);
			n += int'(BUS_CLK_EN);
		end
		check(32'(n >= 2), 32'h1);
		check(32'(exp_q.size()), 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
